// [dv/parallel_word_adapter.sv]
// Behavioural model of the adapter that faces the word port host
`timescale 1ns/10ps
module parallel_word_adapter
  import word_port_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_cmd,
  input wire logic rd_cmd,
  input wire logic wcz_cmd,
  input wire logic flip_par,
  input wire logic [47:0] wr_word,
  input wire logic demand,
  input wire logic record_end,
  input wire logic file_end,
  input wire logic interrupt_req,
  input wire logic suppress_parity,
  input wire word_bus_t in_bus,
  output logic write_select,
  output logic read_select,
  output logic write_ready,
  output logic read_ready,
  output logic word_count_zero,
  output word_bus_t out_bus,
  output word_bus_t got_word,
  output logic got_sup,
  output logic [7:0] got_cnt,
  output logic [2:0] end_st
);
  logic dem_r;
  logic pend_r;
  logic sel;
  assign sel = write_select | read_select;
  // Selects, readies, word buffer and end status {attention, exception, end}
  always_ff @(posedge aclk) begin
    dem_r <= demand;
    if (!aresetn) begin
      {write_select, read_select, write_ready, read_ready} <= 4'h0;
      {pend_r, word_count_zero, got_cnt, end_st, got_sup} <= '0;
      out_bus <= '0;
      got_word <= '0;
    end else if (interrupt_req) begin
      {write_select, read_select, write_ready, read_ready} <= 4'h0;
      word_count_zero <= 1'b0;
      end_st <= end_st | {2'b10, sel};
    end else if (record_end | file_end) begin
      {write_select, read_select, write_ready, read_ready} <= 4'h0;
      word_count_zero <= 1'b0;
      end_st <= end_st | {1'b0, file_end, 1'b1};
    end else begin
      word_count_zero <= wcz_cmd & sel;
      if (wr_cmd | rd_cmd) begin
        end_st <= 3'h0;
        got_sup <= 1'b0;
      end
      if (wr_cmd) begin
        write_select <= 1'b1;
        pend_r <= 1'b1;
        out_bus <= {~^wr_word ^ flip_par, wr_word};
      end
      if (demand) begin
        write_ready <= 1'b0;
      end else if (write_select & pend_r & !dem_r & !wr_cmd) begin
        write_ready <= 1'b1;
      end
      if (demand & !dem_r & write_select) begin
        pend_r <= 1'b0;
        out_bus <= ~out_bus;
      end
      if (rd_cmd) begin
        read_select <= 1'b1;
        read_ready <= 1'b1;
      end else if (demand & read_select) begin
        read_ready <= 1'b0;
        got_sup <= got_sup | (suppress_parity & !read_ready);
        if (!dem_r) begin
          got_word <= in_bus;
          got_cnt <= got_cnt + 8'h1;
        end
      end else if (dem_r & read_select) begin
        read_ready <= 1'b1;
      end
    end
  end
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the word port host
`timescale 1ns/10ps
module tb_top
  import word_port_pkg::*;
();
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic write_select, read_select, write_ready, read_ready, word_count_zero;
  logic demand, record_end, file_end, interrupt_req, suppress_parity;
  logic redundancy_error, wr_cmd, rd_cmd, wcz_cmd, flip_par, got_sup, dq;
  word_bus_t out_bus, in_bus, got_word;
  logic [47:0] wr_word;
  logic [7:0] got_cnt;
  logic [2:0] end_st;
  int fails = 0, total_checks = 0, cyc = 0, dlen = 0, drun = 0, dcnt = 0;

  word_port_host u_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .write_select, .read_select, .write_ready,
    .read_ready, .word_count_zero, .out_bus, .in_bus, .demand, .record_end,
    .file_end, .interrupt_req, .suppress_parity, .redundancy_error);
  parallel_word_adapter u_adp (.aclk, .aresetn, .wr_cmd, .rd_cmd, .wcz_cmd,
    .flip_par, .wr_word, .demand, .record_end, .file_end, .interrupt_req,
    .suppress_parity, .in_bus, .write_select, .read_select, .write_ready,
    .read_ready, .word_count_zero, .out_bus, .got_word, .got_sup, .got_cnt,
    .end_st);

  // Clock, demand pulse counter and width, run watchdog
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    dq <= demand;
    drun <= demand ? drun + 1 : 0;
    if (dq && !demand) dlen <= drun;
    if (demand && !dq) dcnt <= dcnt + 1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string n, input logic [48:0] e,
                     input logic [48:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // AXI4-Lite write, address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awready && !aw) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && !w) s_axi_wvalid <= 1'b0;
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Adapter command pulse, then waits on an end status bit
  task automatic start(input logic w);
    @(posedge aclk);
    wr_cmd <= w;
    rd_cmd <= !w;
    @(posedge aclk);
    wr_cmd <= 1'b0;
    rd_cmd <= 1'b0;
  endtask
  task automatic wait_end(input int b);
    for (int i = 0; i < 400 && end_st[b] !== 1'b1; i++) @(posedge aclk);
    repeat (40) @(posedge aclk);
  endtask

  task automatic t_regs();
    axr(REG_CTRL);
    chk("ctrl reset", 49'(CTRL_RESET), 49'(rd));
    axr(8'h40);
    chk("unmapped rresp", 49'(RESP_SLVERR), 49'(rs));
    axw(8'h40, 32'h0000_ffff);
    chk("unmapped bresp", 49'(RESP_SLVERR), 49'(rs));
  endtask

  task automatic t_write(input logic [15:0] wd, input logic bad);
    int n;
    axw(REG_CTRL, 32'h0000_0029);
    n = dcnt;
    wr_word <= 48'(wd);
    flip_par <= bad;
    start(1'b1);
    for (int i = 0; i < 400 && (dcnt == n || demand); i++) @(posedge aclk);
    @(posedge aclk);
    chk("write demand width", 49'(PULSE_CYC), 49'(dlen));
    chk("redundancy up", 49'(bad), 49'(redundancy_error));
    repeat (40) @(posedge aclk);
    chk("demand count", 49'(n + 1), 49'(dcnt));
    axr(REG_RX_LO);
    chk("rx low", 49'(wd), 49'(rd));
    axr(REG_RX_HI);
    chk("rx parity flag", 49'({bad, 16'h0}), 49'(rd));
    axw(REG_CMD, 32'h0000_0001);
    wait_end(0);
    chk("record end status", 49'h1, 49'(end_st));
    chk("redundancy down", 49'h0, 49'(redundancy_error));
  endtask

  task automatic t_read(input logic [2:0] nb, input logic [47:0] wd,
                        input logic sup);
    logic [7:0] n;
    axw(REG_CTRL, {25'h0, nb, 4'h1});
    axw(REG_TX_LO, wd[31:0]);
    axw(REG_TX_HI, {15'h0, sup, wd[47:32]});
    n = got_cnt;
    start(1'b0);
    for (int i = 0; i < 400 && (got_cnt == n || demand); i++) @(posedge aclk);
    @(posedge aclk);
    chk("read word", {~^wd, wd}, got_word);
    chk("read demand width", 49'(PULSE_CYC), 49'(dlen));
    chk("suppress seen", 49'(sup), 49'(got_sup));
    axw(REG_CMD, 32'h0000_0002);
    wait_end(0);
    chk("file end status", 49'h3, 49'(end_st));
    chk("suppress after", 49'h0, 49'(suppress_parity));
  endtask

  task automatic t_intr();
    axw(REG_CTRL, 32'h0000_0021);
    start(1'b0);
    axw(REG_CMD, 32'h0000_0004);
    wait_end(2);
    chk("interrupt status", 49'h5, 49'(end_st));
    chk("select dropped", 49'h0, 49'(read_select));
  endtask

  // Auto end on word count zero, with suppress strapped on
  task automatic t_auto();
    axw(REG_CTRL, 32'h0000_0027);
    wcz_cmd <= 1'b1;
    start(1'b0);
    wait_end(0);
    chk("auto end status", 49'h1, 49'(end_st));
    chk("strapped suppress", 49'h1, 49'(suppress_parity));
    wcz_cmd <= 1'b0;
  endtask

  // Main sequence
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, wr_cmd, rd_cmd, wcz_cmd, flip_par} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, wr_word} = '0;
    s_axi_wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_write(16'ha5c3, 1'b0);
    t_write(16'h0f0f, 1'b1);
    t_read(3'h2, 48'h0000_0000_1234, 1'b0);
    t_read(3'h6, 48'hfedc_ba98_7654, 1'b1);
    t_intr();
    t_auto();
    close_out();
  end
endmodule

// [rtl/axi_lite_regs.sv]
// AXI4-Lite slave front end producing register strobes
`timescale 1ns/10ps
module axi_lite_regs
  import word_port_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output reg_wr_t reg_wr,
  output logic [7:0] rd_addr,
  output logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic rd_err,
  input wire logic wr_err
);

  logic aw_full_r, w_full_r, aw_full_nxt, w_full_nxt, b_done;
  logic wr_en_r, rd_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] wr_data_r;
  logic [3:0] wr_strb_r;

  // Address and data may arrive in either order
  assign b_done = s_axi_bvalid && s_axi_bready;
  assign aw_full_nxt = (s_axi_awvalid && s_axi_awready) ? 1'b1 :
                       b_done ? 1'b0 : aw_full_r;
  assign w_full_nxt = (s_axi_wvalid && s_axi_wready) ? 1'b1 :
                      b_done ? 1'b0 : w_full_r;
  assign reg_wr = '{en: wr_en_r, addr: wr_addr_r, data: wr_data_r,
                    strb: wr_strb_r};

  // Write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      wr_en_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 32'h0000_0000;
      wr_strb_r <= 4'h0;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      s_axi_awready <= !aw_full_nxt;
      s_axi_wready <= !w_full_nxt;
      wr_en_r <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data_r <= s_axi_wdata;
        wr_strb_r <= s_axi_wstrb;
      end
      if (aw_full_r && w_full_r && !s_axi_bvalid) begin
        wr_en_r <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (b_done) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel, data latched one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
      rd_addr <= 8'h00;
      rd_en <= 1'b0;
      rd_pend_r <= 1'b0;
    end else begin
      rd_en <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        rd_addr <= s_axi_araddr;
        s_axi_arready <= 1'b0;
        rd_pend_r <= 1'b1;
      end else if (rd_pend_r) begin
        rd_pend_r <= 1'b0;
        rd_en <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// [rtl/word_port_host.sv]
// External party of the demand-response parallel word port
//
// Function
// - Sample outbound only with write select, ready
// - Inbound data stable for whole demand pulse
// - One demand per write ready
// - Read data valid before and after demand
// - Demand at least 800 ns, drops promptly
// - Redundancy error only under write select
// - Suppress changes only in demand window; the strap sets it at any time
// - Suppress off soon after select falls; the strap holds it on
// - End pulses at least 800 ns
// - Word count zero asks for an end
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
module word_port_host
  import word_port_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic write_select,
  input wire logic read_select,
  input wire logic write_ready,
  input wire logic read_ready,
  input wire logic word_count_zero,
  input wire word_bus_t out_bus,
  output word_bus_t in_bus,
  output logic demand,
  output logic record_end,
  output logic file_end,
  output logic interrupt_req,
  output logic suppress_parity,
  output logic redundancy_error
);

  localparam int DROP_MAX = SEL_DROP_CYC;

  reg_wr_t reg_wr;
  logic [7:0] rd_addr;
  logic rd_en, rd_err, wr_err;
  logic [31:0] rd_data;
  logic [31:0] ctrl_r, tx_lo_r;
  logic [16:0] tx_hi_r;
  logic tx_pending_r, rx_valid_r, rx_perr_r, sup_word_r;
  logic [WORD_MAX-1:0] rx_word_r, mask, tx_word;
  logic rec_pend_r, file_pend_r, intr_pend_r, red_pend_r;
  logic end_done_r, wr_armed_r;
  host_state_t state_r;
  logic [7:0] cnt_r;
  logic [2:0] wb_raw, wb;
  logic sel_any, pulse_done, idle, go_end;
  logic start_intr, start_end, start_write, start_read;
  logic wr_ctrl, wr_cmd, wr_tx_lo, wr_tx_hi, rd_rx_hi;

  axi_lite_regs u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .reg_wr(reg_wr),
    .rd_addr(rd_addr),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .rd_err(rd_err),
    .wr_err(wr_err)
  );

  // Byte-enable merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input reg_wr_t w);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{w.strb[b]}};
    end
    return (old & ~m) | (w.data & m);
  endfunction

  // Register strobes
  assign wr_ctrl = reg_wr.en && reg_wr.addr == REG_CTRL;
  assign wr_cmd = reg_wr.en && reg_wr.addr == REG_CMD;
  assign wr_tx_lo = reg_wr.en && reg_wr.addr == REG_TX_LO;
  assign wr_tx_hi = reg_wr.en && reg_wr.addr == REG_TX_HI;
  assign rd_rx_hi = rd_en && rd_addr == REG_RX_HI;
  assign wr_err = !(reg_wr.addr inside {REG_CTRL, REG_CMD, REG_TX_LO,
                  REG_TX_HI, REG_RX_LO, REG_RX_HI, REG_STATUS});

  // Read decode
  always_comb begin
    rd_err = 1'b0;
    rd_data = 32'h0000_0000;
    case (rd_addr)
      REG_CTRL: rd_data = ctrl_r;
      REG_CMD: rd_data = {28'h0, red_pend_r, intr_pend_r, file_pend_r,
                          rec_pend_r};
      REG_TX_LO: rd_data = tx_lo_r;
      REG_TX_HI: rd_data = {15'h0, tx_hi_r};
      REG_RX_LO: rd_data = rx_word_r[31:0];
      REG_RX_HI: rd_data = {15'h0, rx_perr_r, rx_word_r[47:32]};
      REG_STATUS: rd_data = {26'h0, state_r != ST_IDLE, rx_valid_r,
                             tx_pending_r, word_count_zero, read_select,
                             write_select};
      default: rd_err = 1'b1;
    endcase
  end

  // Word width, clamped to 2..6 bytes
  assign wb_raw = ctrl_r[CTRL_WIDTH_LSB +: 3];
  assign wb = (wb_raw < BYTES_MIN_V) ? BYTES_MIN_V :
              (wb_raw > BYTES_MAX_V) ? BYTES_MAX_V : wb_raw;

  // Active byte lanes of the word
  for (genvar i = 0; i < BYTES_MAX; i++) begin : g_lane
    assign mask[i*8 +: 8] = {8{3'(i) < wb}};
  end

  assign tx_word = {tx_hi_r[15:0], tx_lo_r} & mask;

  // Sequencing decisions
  assign sel_any = write_select || read_select;
  assign idle = state_r == ST_IDLE;
  assign pulse_done = cnt_r == PULSE_LAST;
  assign go_end = rec_pend_r || file_pend_r ||
                  (ctrl_r[CTRL_AUTO_END] && word_count_zero && sel_any &&
                   !end_done_r);
  assign start_intr = idle && intr_pend_r;
  assign start_end = idle && !intr_pend_r && go_end;
  assign start_write = idle && !intr_pend_r && !go_end &&
                       ctrl_r[CTRL_RESPOND] && write_select &&
                       write_ready && wr_armed_r &&
                       !rx_valid_r;
  assign start_read = idle && !intr_pend_r && !go_end && !start_write &&
                      ctrl_r[CTRL_RESPOND] && read_select && read_ready &&
                      tx_pending_r;

  // Configuration and outgoing word registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RESET;
      tx_lo_r <= 32'h0000_0000;
      tx_hi_r <= 17'h0;
    end else begin
      if (wr_ctrl) ctrl_r <= merge(ctrl_r, reg_wr);
      if (wr_tx_lo) tx_lo_r <= merge(tx_lo_r, reg_wr);
      if (wr_tx_hi) tx_hi_r <= 17'(merge({15'h0, tx_hi_r}, reg_wr));
    end
  end

  // Pending requests; a new request wins over its own clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rec_pend_r <= 1'b0;
      file_pend_r <= 1'b0;
      intr_pend_r <= 1'b0;
      red_pend_r <= 1'b0;
      tx_pending_r <= 1'b0;
    end else begin
      if (wr_cmd && reg_wr.data[CMD_REC_END]) rec_pend_r <= 1'b1;
      else if (start_end) rec_pend_r <= 1'b0;
      if (wr_cmd && reg_wr.data[CMD_FILE_END]) file_pend_r <= 1'b1;
      else if (start_end) file_pend_r <= 1'b0;
      if (wr_cmd && reg_wr.data[CMD_INTR]) intr_pend_r <= 1'b1;
      else if (start_intr) intr_pend_r <= 1'b0;
      if (wr_cmd && reg_wr.data[CMD_REDUND]) red_pend_r <= 1'b1;
      else if (write_select) red_pend_r <= 1'b0;
      if (wr_tx_hi) tx_pending_r <= 1'b1;
      else if (start_read) tx_pending_r <= 1'b0;
    end
  end

  // Sequencer state and pulse counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          cnt_r <= 8'h00;
          if (start_intr) state_r <= ST_INTR;
          else if (start_end) state_r <= ST_END;
          else if (start_write) state_r <= ST_DEMAND;
          else if (start_read) state_r <= ST_SETUP;
        end
        ST_SETUP: state_r <= ST_DEMAND;
        ST_DEMAND, ST_END, ST_INTR: begin
          cnt_r <= cnt_r + 8'h01;
          if (pulse_done) state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Demand: one fixed-width pulse per accepted word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      demand <= 1'b0;
    end else if (start_write || state_r == ST_SETUP) begin
      demand <= 1'b1;
    end else if (state_r == ST_DEMAND && pulse_done) begin
      demand <= 1'b0;
    end
  end

  // Write arming: wait for ready to fall before the next demand
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_armed_r <= 1'b1;
    end else if (start_write) begin
      wr_armed_r <= 1'b0;
    end else if (!write_ready) begin
      wr_armed_r <= 1'b1;
    end
  end

  // End and interrupt pulses; file end governs record end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      record_end <= 1'b0;
      file_end <= 1'b0;
      interrupt_req <= 1'b0;
      end_done_r <= 1'b0;
    end else begin
      if (start_end) begin
        record_end <= !file_pend_r;
        file_end <= file_pend_r;
        end_done_r <= 1'b1;
      end else begin
        if (state_r == ST_END && pulse_done) begin
          record_end <= 1'b0;
          file_end <= 1'b0;
        end
        if (!sel_any) end_done_r <= 1'b0;
      end
      if (start_intr) interrupt_req <= 1'b1;
      else if (state_r == ST_INTR && pulse_done) interrupt_req <= 1'b0;
    end
  end

  // Captured outbound word and its parity check
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_word_r <= '0;
      rx_perr_r <= 1'b0;
      rx_valid_r <= 1'b0;
    end else begin
      if (start_write) begin
        rx_word_r <= out_bus.data & mask;
        rx_perr_r <= !(^(out_bus.data & mask) ^ out_bus.parity);
      end
      if (start_write) rx_valid_r <= 1'b1;
      else if (rd_rx_hi) rx_valid_r <= 1'b0;
    end
  end

  // Inbound word, held from before demand until the next word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_bus <= '0;
      sup_word_r <= 1'b0;
    end else if (start_read) begin
      in_bus <= '{parity: ~^tx_word, data: tx_word};
      sup_word_r <= tx_hi_r[HI_SUP];
    end
  end

  // Suppress-parity line: the strap forces it on, no select clears it, otherwise moved inside the demand window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      suppress_parity <= 1'b0;
    end else if (ctrl_r[CTRL_STRAP_SUP]) begin
      suppress_parity <= 1'b1;
    end else if (!sel_any) begin
      suppress_parity <= 1'b0;
    end else if (state_r == ST_DEMAND && read_select && !read_ready) begin
      suppress_parity <= sup_word_r;
    end
  end

  // Redundancy error, only under write select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      redundancy_error <= 1'b0;
    end else if (!write_select) begin
      redundancy_error <= 1'b0;
    end else if (red_pend_r || (start_write && ctrl_r[CTRL_ERR_REPORT] &&
                 !(^(out_bus.data & mask) ^ out_bus.parity))) begin
      redundancy_error <= 1'b1;
    end
  end

  // Helper: length of each outgoing pulse
  logic [3:0] pw_sig;
  logic [7:0] pw_cnt [4];
  assign pw_sig = {interrupt_req, file_end, record_end, demand};
  for (genvar p = 0; p < 4; p++) begin : g_pw
    always_ff @(posedge aclk) begin
      if (!aresetn) pw_cnt[p] <= 8'h00;
      else if (pw_sig[p]) pw_cnt[p] <= pw_cnt[p] + 8'h01;
      else pw_cnt[p] <= 8'h00;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_demand_width: assert property (
    $fell(demand) |-> pw_cnt[0] == 8'(PULSE_CYC))
    else $error("demand pulse width wrong");
  a_end_width: assert property (
    $fell(record_end || file_end) |->
      (pw_cnt[1] == 8'(PULSE_CYC) || pw_cnt[2] == 8'(PULSE_CYC)))
    else $error("end pulse width wrong");
  a_intr_width: assert property (
    $fell(interrupt_req) |->
      pw_cnt[3] >= 8'(PULSE_CYC) && pw_cnt[3] <= 8'(SEL_DROP_CYC))
    else $error("interrupt pulse width out of range");
  a_write_sample_ok: assert property (
    $rose(demand) && $past(write_select) |->
      $past(write_ready) && rx_valid_r)
    else $error("write demand without ready");
  a_read_data_hold: assert property (
    demand && read_select |-> $stable(in_bus))
    else $error("inbound data changed under demand");
  a_read_setup: assert property (
    $rose(demand) && !$past(write_select) |-> $past(state_r) == ST_SETUP)
    else $error("read demand without data setup");
  a_one_demand: assert property (
    start_write |-> wr_armed_r ##1 !wr_armed_r)
    else $error("second demand on one write ready");
  a_redund_sel: assert property (
    redundancy_error |-> $past(write_select))
    else $error("redundancy error outside write select");
  a_sup_release: assert property (
    !sel_any && !ctrl_r[CTRL_STRAP_SUP] |=> !suppress_parity)
    else $error("suppress held after select fell");
  a_demand_drop: assert property (
    $fell(sel_any) |-> ##[0:DROP_MAX] !demand)
    else $error("demand not dropped after select fell");

  c_write_word: cover property ($fell(demand) && write_select);
  c_read_word: cover property ($fell(demand) && read_select);
  c_file_end: cover property ($rose(file_end));
  c_interrupt: cover property ($rose(interrupt_req) && sel_any);

endmodule

// [rtl/word_port_pkg.sv]
// Constants, register map and carrier types for the word port host
package word_port_pkg;

  // Timing, derived from the 40 MHz clock
  localparam int CLK_NS = 25;
  localparam int PULSE_MIN_NS = 800;
  localparam int SEL_DROP_NS = 2000;
  localparam int PULSE_CYC = (PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SEL_DROP_CYC = SEL_DROP_NS / CLK_NS;
  localparam logic [7:0] PULSE_LAST = 8'(PULSE_CYC - 1);

  // Word geometry
  localparam int WORD_MAX = 48;
  localparam int BYTES_MAX = 6;
  localparam logic [2:0] BYTES_MIN_V = 3'h2;
  localparam logic [2:0] BYTES_MAX_V = 3'h6;

  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_TX_LO = 8'h08;
  localparam logic [7:0] REG_TX_HI = 8'h0c;
  localparam logic [7:0] REG_RX_LO = 8'h10;
  localparam logic [7:0] REG_RX_HI = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  // Control fields
  localparam int CTRL_RESPOND = 0;
  localparam int CTRL_AUTO_END = 1;
  localparam int CTRL_STRAP_SUP = 2;
  localparam int CTRL_ERR_REPORT = 3;
  localparam int CTRL_WIDTH_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0021;

  // Command bits, write one to request
  localparam int CMD_REC_END = 0;
  localparam int CMD_FILE_END = 1;
  localparam int CMD_INTR = 2;
  localparam int CMD_REDUND = 3;

  // Upper word fields
  localparam int HI_SUP = 16;
  localparam int HI_PERR = 16;

  // Status bits
  localparam int ST_WSEL = 0;
  localparam int ST_RSEL = 1;
  localparam int ST_WCZ = 2;
  localparam int ST_TXP = 3;
  localparam int ST_RXV = 4;
  localparam int ST_BUSY = 5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Parallel word with its parity line
  typedef struct packed {
    logic parity;
    logic [WORD_MAX-1:0] data;
  } word_bus_t;

  // Register write strobe from the bus slave
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } reg_wr_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_DEMAND,
    ST_END,
    ST_INTR
  } host_state_t;

endpackage
